// *** rtl/adcc_ctrl.sv ***
// converter control block: APB registers, trigger logic and conversion sequencer
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - store 10-bit result in bits 9..0, or 8-bit result in bits 7..0
// - with sample-hold, conversion takes 28 cycles at 8-bit, 33 at 10-bit
// - sample for 2 cycles without sample-hold, 3 with it
// - software trigger: start as soon as the start bit is written 1
// - hardware trigger code picks pin edge, timer B2 or timer A0 request
// - hardware triggers start conversion only while start bit already holds 1
// - hardware trigger during sampling or conversion aborts it and restarts from the beginning
// - dma mode puts every result in register zero and pulses a request per pin
// - extended-pin field selects unused, first input, second input or op-amp
// - one-shot/repeat: extended results go to registers zero and one
// - op-amp mode drives channel out first pin, converts second, stores per channel
// - assist enable picks open-circuit or self-test, pull-up or pull-down
// - results undefined after halting by clearing start bit
// - halting single sweep raises no interrupt
// - repeat modes with dma request an interrupt after each conversion
// - single sweep without dma raises one interrupt when the sweep ends
module adcc_ctrl #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_I,
  // apb slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [7:0]        PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output var  logic [31:0]       PRDATA_O,
  output var  logic              PREADY_O,
  output var  logic              PSLVERR_O,
  // trigger sources
  input  wire logic              EXT_TRIGGER_PIN_I,
  input  wire logic              TB2_REQ_I,
  input  wire logic              TA0_REQ_I,
  // analog core
  input  wire logic [RES_W-1:0]  CONV_DATA_I,
  output var  adcc_pkg::adcc_afe_s AFE_O,
  // events
  output var  logic              DMA_REQ_O,
  output var  logic              CONV_IRQ_O
);

  adcc_pkg::adcc_state_s q_ff;
  adcc_pkg::adcc_state_s nxt_q;

  logic       wr_acc;
  logic       rd_acc;
  logic       sh_en;
  logic       res10;
  logic       dma_on;
  logic       start_b;
  logic [2:0] mode;
  logic [1:0] ext_cfg;
  logic       trig_hw;
  logic       pin_fall;
  logic [5:0] conv_len;
  logic [5:0] samp_len;
  logic [2:0] sweep_last;
  logic       sweep_mode;
  logic [2:0] store_idx;
  logic [9:0] conv_val;

  // apb access phase; registered pready gives one wait state
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;

  // decoded control fields
  assign sh_en   = q_ff.ctrl_c[adcc_pkg::SMP_BIT];
  assign res10   = q_ff.ctrl_b[adcc_pkg::RES_BIT];
  assign dma_on  = q_ff.ctrl_d;
  assign start_b = q_ff.ctrl_a[adcc_pkg::START_BIT];
  assign mode    = {q_ff.ctrl_b[adcc_pkg::MDX_BIT], q_ff.ctrl_a[adcc_pkg::MD_LSB +: 2]};
  assign ext_cfg = q_ff.ctrl_b[adcc_pkg::EXT_LSB +: 2];
  assign sweep_mode = (mode == adcc_pkg::MODE_SWP) || (mode == adcc_pkg::MODE_RSW0)
                      || (mode == adcc_pkg::MODE_RSW1);
  assign sweep_last = {q_ff.ctrl_b[adcc_pkg::SWP_LSB +: 2], 1'b1};

  // falling edge from two synchronised samples, never the first stage
  assign pin_fall = q_ff.trg_s3 && !q_ff.trg_s2;

  always_comb
  begin
    case (q_ff.ctrl_c[adcc_pkg::HWT_LSB +: 2])
      adcc_pkg::HWT_PIN: trig_hw = pin_fall;
      adcc_pkg::HWT_TB2: trig_hw = TB2_REQ_I;
      adcc_pkg::HWT_TA0: trig_hw = TA0_REQ_I;
      default:           trig_hw = 1'b0;
    endcase
  end

  // conversion length; without sample-hold a longer plain rate is used
  assign conv_len = sh_en ? (res10 ? adcc_pkg::CONV_10_SH : adcc_pkg::CONV_8_SH)
                          : (res10 ? adcc_pkg::CONV_10_NS : adcc_pkg::CONV_8_NS);
  assign samp_len = sh_en ? adcc_pkg::SAMP_SH : adcc_pkg::SAMP_NS;

  assign conv_val = res10 ? 10'(CONV_DATA_I) : {2'b00, CONV_DATA_I[RES_W-1 -: 8]};

  // result destination: dma folds all into zero, ext pins to zero/one
  always_comb
  begin
    if (dma_on)
      store_idx = 3'h0;
    else if (ext_cfg == adcc_pkg::EXT_FST)
      store_idx = 3'h0;
    else if (ext_cfg == adcc_pkg::EXT_SND)
      store_idx = 3'h1;
    else
      store_idx = q_ff.chan;
  end

  // next state: registers, sequencer and pin synchroniser
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.dma_req = 1'b0;
    nxt_q.pready  = 1'b0;
    nxt_q.pslverr = 1'b0;
    nxt_q.trg_s1  = EXT_TRIGGER_PIN_I;
    nxt_q.trg_s2  = q_ff.trg_s1;
    nxt_q.trg_s3  = q_ff.trg_s2;
    // register writes
    if (wr_acc && !q_ff.pready)
    begin
      nxt_q.pready = 1'b1;
      case (PADDR_I)
        adcc_pkg::OFS_CTRL_A: nxt_q.ctrl_a = PWDATA_I[6:0];
        adcc_pkg::OFS_CTRL_B: nxt_q.ctrl_b = PWDATA_I[7:0];
        adcc_pkg::OFS_CTRL_C: nxt_q.ctrl_c = PWDATA_I[6:0];
        adcc_pkg::OFS_CTRL_D: nxt_q.ctrl_d = PWDATA_I[adcc_pkg::DMA_BIT];
        adcc_pkg::OFS_CTRL_F: nxt_q.ctrl_f = PWDATA_I[2:0];
        // irq flag cleared by writing 1 to it
        adcc_pkg::OFS_STATUS: if (PWDATA_I[adcc_pkg::ST_IRQ]) nxt_q.irq = 1'b0;
        default:              nxt_q.pslverr = (PADDR_I < adcc_pkg::OFS_RES0)
                                              || (PADDR_I > adcc_pkg::OFS_RES_HI);
      endcase
    end
    // register reads
    if (rd_acc && !q_ff.pready)
    begin
      nxt_q.pready = 1'b1;
      nxt_q.prdata = 32'h0000_0000;
      case (PADDR_I)
        adcc_pkg::OFS_CTRL_A: nxt_q.prdata[6:0] = q_ff.ctrl_a;
        adcc_pkg::OFS_CTRL_B: nxt_q.prdata[7:0] = q_ff.ctrl_b;
        adcc_pkg::OFS_CTRL_C: nxt_q.prdata[6:0] = q_ff.ctrl_c;
        adcc_pkg::OFS_CTRL_D: nxt_q.prdata[0]   = q_ff.ctrl_d;
        adcc_pkg::OFS_CTRL_F: nxt_q.prdata[2:0] = q_ff.ctrl_f;
        adcc_pkg::OFS_STATUS: nxt_q.prdata[1:0] = {q_ff.irq, q_ff.st != adcc_pkg::ST_IDLE};
        default:
          if (PADDR_I >= adcc_pkg::OFS_RES0 && PADDR_I <= adcc_pkg::OFS_RES_HI
              && PADDR_I[1:0] == 2'b00)
            nxt_q.prdata[9:0] = q_ff.res[10*PADDR_I[4:2] +: 10];
          else
            nxt_q.pslverr = 1'b1;
      endcase
    end
    // sequencer; a cleared start bit halts at once, results left as they are
    case (q_ff.st)
      adcc_pkg::ST_IDLE:
        if (nxt_q.ctrl_a[adcc_pkg::START_BIT])
        begin
          nxt_q.chan = sweep_mode ? 3'h0 : nxt_q.ctrl_a[adcc_pkg::CH_LSB +: 3];
          // software trigger starts immediately; hardware waits
          nxt_q.st  = nxt_q.ctrl_a[adcc_pkg::TRG_BIT] ? adcc_pkg::ST_WAIT : adcc_pkg::ST_SAMP;
          nxt_q.cnt = samp_len;
        end
      adcc_pkg::ST_WAIT:
        if (trig_hw)
        begin
          nxt_q.st  = adcc_pkg::ST_SAMP;
          nxt_q.cnt = samp_len;
        end
      adcc_pkg::ST_SAMP:
        if (q_ff.cnt == 6'h01)
        begin
          nxt_q.st  = adcc_pkg::ST_CONV;
          nxt_q.cnt = conv_len - samp_len;
        end
        else
          nxt_q.cnt = q_ff.cnt - 6'h01;
      adcc_pkg::ST_CONV:
        if (q_ff.cnt == 6'h01)
        begin
          nxt_q.res[10*store_idx +: 10] = conv_val;
          // one transfer request per converted pin
          nxt_q.dma_req = dma_on;
          nxt_q.cnt     = samp_len;
          nxt_q.st      = adcc_pkg::ST_SAMP;
          if (sweep_mode && q_ff.chan != sweep_last)
            nxt_q.chan = q_ff.chan + 3'h1;
          else
          begin
            nxt_q.chan = sweep_mode ? 3'h0 : q_ff.chan;
            // single sweep end or one-shot end; interrupt here only without dma
            if (mode == adcc_pkg::MODE_ONE || mode == adcc_pkg::MODE_SWP)
            begin
              nxt_q.st = adcc_pkg::ST_IDLE;
              nxt_q.ctrl_a[adcc_pkg::START_BIT] = 1'b0;
              nxt_q.irq = nxt_q.irq | !dma_on;
            end
          end
          // dma mode requests an interrupt after each conversion
          if (dma_on)
            nxt_q.irq = 1'b1;
        end
        else
          nxt_q.cnt = q_ff.cnt - 6'h01;
      default: nxt_q.st = adcc_pkg::ST_IDLE;
    endcase
    // hardware trigger mid-conversion restarts the operation
    if (q_ff.ctrl_a[adcc_pkg::TRG_BIT] && trig_hw
        && (q_ff.st == adcc_pkg::ST_SAMP || q_ff.st == adcc_pkg::ST_CONV))
    begin
      nxt_q.st   = adcc_pkg::ST_SAMP;
      nxt_q.cnt  = samp_len;
      nxt_q.chan = sweep_mode ? 3'h0 : q_ff.ctrl_a[adcc_pkg::CH_LSB +: 3];
    end
    // cleared start halts at once; a cut sweep raises no interrupt
    if (!nxt_q.ctrl_a[adcc_pkg::START_BIT])
      nxt_q.st = adcc_pkg::ST_IDLE;
    // start bit held while active so software cannot see a stale stop
    if (nxt_q.st != adcc_pkg::ST_IDLE && q_ff.st != adcc_pkg::ST_IDLE
        && !(wr_acc && PADDR_I == adcc_pkg::OFS_CTRL_A))
      nxt_q.ctrl_a[adcc_pkg::START_BIT] = 1'b1;
    // analog front-end drive
    nxt_q.afe.channel = nxt_q.chan;
    nxt_q.afe.sample  = nxt_q.st == adcc_pkg::ST_SAMP;
    nxt_q.afe.convert = nxt_q.st == adcc_pkg::ST_CONV;
    nxt_q.afe.ext_first_in  = nxt_q.ctrl_b[adcc_pkg::EXT_LSB +: 2] == adcc_pkg::EXT_FST;
    nxt_q.afe.ext_second_in = nxt_q.ctrl_b[adcc_pkg::EXT_LSB +: 2] == adcc_pkg::EXT_SND
                              || nxt_q.ctrl_b[adcc_pkg::EXT_LSB +: 2] == adcc_pkg::EXT_OPA;
    nxt_q.afe.opamp_drive   = nxt_q.ctrl_b[adcc_pkg::EXT_LSB +: 2] == adcc_pkg::EXT_OPA;
    nxt_q.afe.pull_en   = nxt_q.ctrl_f[adcc_pkg::AEN_BIT];
    nxt_q.afe.self_test = nxt_q.ctrl_f[adcc_pkg::AEN_BIT] && nxt_q.ctrl_f[adcc_pkg::ASEL_BIT];
    nxt_q.afe.pull_down = nxt_q.ctrl_f[adcc_pkg::AEN_BIT] && nxt_q.ctrl_f[adcc_pkg::APUL_BIT];
    nxt_q.afe.ref_on    = nxt_q.ctrl_b[adcc_pkg::REF_BIT];
  end

  // state register
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  // outputs straight from flops
  assign PRDATA_O   = q_ff.prdata;
  assign PREADY_O   = q_ff.pready;
  assign PSLVERR_O  = q_ff.pslverr;
  assign AFE_O      = q_ff.afe;
  assign DMA_REQ_O  = q_ff.dma_req;
  assign CONV_IRQ_O = q_ff.irq;

  // helper: cycles spent in current sample window
  logic [5:0] samp_run_ff;
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
      samp_run_ff <= 6'h00;
    else if (q_ff.st == adcc_pkg::ST_SAMP && !(q_ff.ctrl_a[adcc_pkg::TRG_BIT] && trig_hw))
      samp_run_ff <= samp_run_ff + 6'h01;
    else
      samp_run_ff <= 6'h00;
  end

  // helper: cycles spent in current conversion phase; a retrigger leaves it
  logic [5:0] conv_run_ff;
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
      conv_run_ff <= 6'h00;
    else if (q_ff.st == adcc_pkg::ST_CONV)
      conv_run_ff <= conv_run_ff + 6'h01;
    else
      conv_run_ff <= 6'h00;
  end

  sequence samp_end_s;
    q_ff.st == adcc_pkg::ST_SAMP ##1 q_ff.st == adcc_pkg::ST_CONV;
  endsequence

  samp_len_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    samp_end_s |-> $past(samp_run_ff) == samp_len - 6'h01)
    else $error("sampling window wrong length");

  // sample-hold 8-bit conversion spans 28 cycles
  conv_8sh_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    q_ff.st == adcc_pkg::ST_CONV && q_ff.cnt == 6'h01 && sh_en && !res10
    |-> conv_run_ff == adcc_pkg::CONV_8_SH - adcc_pkg::SAMP_SH - 6'h01)
    else $error("8-bit conversion length wrong");

  // software start enters sampling next cycle
  sw_start_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    q_ff.st == adcc_pkg::ST_IDLE && wr_acc && !q_ff.pready
    && PADDR_I == adcc_pkg::OFS_CTRL_A && PWDATA_I[adcc_pkg::START_BIT]
    && !PWDATA_I[adcc_pkg::TRG_BIT] |=> q_ff.st == adcc_pkg::ST_SAMP)
    else $error("software start not taken");

  // waiting state leaves only on trigger
  hw_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    q_ff.st == adcc_pkg::ST_WAIT && !trig_hw && start_b && !wr_acc
    |=> q_ff.st == adcc_pkg::ST_WAIT)
    else $error("left wait without trigger");

  retrig_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    q_ff.st == adcc_pkg::ST_CONV && q_ff.ctrl_a[adcc_pkg::TRG_BIT] && trig_hw
    && start_b && !wr_acc |=> q_ff.st == adcc_pkg::ST_SAMP && q_ff.cnt == samp_len)
    else $error("retrigger did not restart");

  // dma request pulse lasts one cycle and only in dma mode
  dma_pulse_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    DMA_REQ_O |-> dma_on ##1 !DMA_REQ_O)
    else $error("dma request malformed");

  res_width_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    q_ff.st == adcc_pkg::ST_CONV && q_ff.cnt == 6'h01 && !res10 && start_b && !wr_acc
    |=> q_ff.res[10*$past(store_idx) + 8 +: 2] == 2'b00)
    else $error("8-bit result overflows");

  // synchronised pin edge starts a conversion waiting on the pin
  pin_edge_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    pin_fall && q_ff.st == adcc_pkg::ST_WAIT && start_b && !wr_acc
    && q_ff.ctrl_c[adcc_pkg::HWT_LSB +: 2] == adcc_pkg::HWT_PIN
    |=> q_ff.st == adcc_pkg::ST_SAMP)
    else $error("pin edge detection wrong");

endmodule : adcc_ctrl

`default_nettype wire

// *** rtl/adcc_pkg.sv ***
// package: register map, field positions, timing constants and carriers for the converter control
package adcc_pkg;
  // register byte offsets (APB, one aligned word each)
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_CTRL_D = 8'h0C;
  localparam logic [7:0] OFS_CTRL_F = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RES0   = 8'h20;
  localparam logic [7:0] OFS_RES_HI = 8'h3C;
  // conv_ctrl_a fields
  localparam int CH_LSB    = 0;   // channel select, 3 bits
  localparam int MD_LSB    = 3;   // op mode low two bits
  localparam int TRG_BIT   = 5;   // trigger source bit
  localparam int START_BIT = 6;   // conversion start bit
  // conv_ctrl_b fields
  localparam int SWP_LSB   = 0;   // sweep count, 2 bits
  localparam int MDX_BIT   = 2;   // op mode extension
  localparam int RES_BIT   = 3;   // resolution select
  localparam int REF_BIT   = 5;   // reference connect
  localparam int EXT_LSB   = 6;   // extended pin config, 2 bits
  // conv_ctrl_c fields
  localparam int SMP_BIT   = 0;   // sample-and-hold enable
  localparam int GRP_LSB   = 1;   // pin group select, 2 bits
  localparam int HWT_LSB   = 5;   // hw trigger select, 2 bits
  // conv_ctrl_d / conv_ctrl_f fields
  localparam int DMA_BIT   = 0;
  localparam int AEN_BIT   = 0;
  localparam int ASEL_BIT  = 1;
  localparam int APUL_BIT  = 2;
  // status bits
  localparam int ST_BUSY   = 0;
  localparam int ST_IRQ    = 1;
  // timing in converter clock cycles
  localparam logic [5:0] CONV_8_SH   = 6'h1C; // 28 cycles
  localparam logic [5:0] CONV_10_SH  = 6'h21; // 33 cycles
  localparam logic [5:0] CONV_8_NS   = 6'h2F; // 47 cycles, plain mode
  localparam logic [5:0] CONV_10_NS  = 6'h3B; // 59 cycles, plain mode
  localparam logic [5:0] SAMP_NS     = 6'h02;
  localparam logic [5:0] SAMP_SH     = 6'h03;
  // hardware trigger codes
  localparam logic [1:0] HWT_PIN  = 2'h0;
  localparam logic [1:0] HWT_TB2  = 2'h1;
  localparam logic [1:0] HWT_TA0  = 2'h2;
  // extended pin configuration
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_FST  = 2'h1;
  localparam logic [1:0] EXT_SND  = 2'h2;
  localparam logic [1:0] EXT_OPA  = 2'h3;
  // operating modes {ext, hi, lo}
  localparam logic [2:0] MODE_ONE   = 3'h0;
  localparam logic [2:0] MODE_REP   = 3'h1;
  localparam logic [2:0] MODE_SWP   = 3'h2;
  localparam logic [2:0] MODE_RSW0  = 3'h3;
  localparam logic [2:0] MODE_RSW1  = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SAMP = 2'b10,
    ST_CONV = 2'b11
  } adcc_state_e;

  // analog front-end control bundle
  typedef struct packed {
    logic [2:0] channel;
    logic       sample;
    logic       convert;
    logic       ext_first_in;
    logic       ext_second_in;
    logic       opamp_drive;
    logic       pull_en;
    logic       pull_down;
    logic       self_test;
    logic       ref_on;
  } adcc_afe_s;

  // whole module state
  typedef struct packed {
    adcc_state_e  st;
    logic [6:0]   ctrl_a;
    logic [7:0]   ctrl_b;
    logic [6:0]   ctrl_c;
    logic         ctrl_d;
    logic [2:0]   ctrl_f;
    logic [5:0]   cnt;
    logic [2:0]   chan;
    logic [2:0]   idx;
    logic         irq;
    logic         dma_req;
    logic         trg_s1;
    logic         trg_s2;
    logic         trg_s3;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    adcc_afe_s    afe;
    logic [79:0]  res;
  } adcc_state_s;
endpackage : adcc_pkg

// *** dv/adcc_far_model.sv ***
// far-side model: analog core result and the trigger sources
`timescale 1ns/1ns
`default_nettype none
module adcc_far_model #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // bench commands
  input  wire logic                fire_i,
  input  wire logic [1:0]          fire_code_i,
  input  wire logic [RES_W-1:0]    conv_val_i,
  // towards the block
  input  wire adcc_pkg::adcc_afe_s afe_i,
  output var  logic                pin_o,
  output var  logic                tb2_o,
  output var  logic                ta0_o,
  output var  logic [RES_W-1:0]    conv_data_o
);
  logic [RES_W-1:0] noise_ff;
  logic [2:0]       pin_cnt_ff;

  // timer requests are one-cycle pulses; the pin is held low for a few cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      noise_ff   <= '0;
      pin_cnt_ff <= 3'h0;
      tb2_o      <= 1'b0;
      ta0_o      <= 1'b0;
    end
    else
    begin
      noise_ff <= noise_ff + RES_W'(10'h2a7);
      tb2_o    <= fire_i && (fire_code_i == adcc_pkg::HWT_TB2);
      ta0_o    <= fire_i && (fire_code_i == adcc_pkg::HWT_TA0);
      if (fire_i && (fire_code_i == adcc_pkg::HWT_PIN))
        pin_cnt_ff <= 3'h4;
      else if (pin_cnt_ff != 3'h0)
        pin_cnt_ff <= pin_cnt_ff - 3'h1;
    end
  end

  // pin idles high, so one low pulse gives exactly one falling edge
  assign pin_o = (pin_cnt_ff == 3'h0);
  // steady only while converting, so a sample taken at the wrong time is caught
  assign conv_data_o = afe_i.convert ? conv_val_i : (~conv_val_i ^ noise_ff);
endmodule // adcc_far_model
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                clk;
  logic                rst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                pin;
  logic                tb2;
  logic                ta0;
  logic [9:0]          conv_data;
  logic [9:0]          conv_val;
  logic                fire;
  logic [1:0]          fire_code;
  logic                dma_req;
  logic                irq;
  adcc_pkg::adcc_afe_s afe;
  adcc_pkg::adcc_afe_s afe_cap;
  logic [31:0]         rd;
  logic                se;
  int                  err_total;
  int                  compares;
  int                  dma_cnt;

  adcc_ctrl #(.RES_W(10)) adcc_ctrl_i (
    .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_TRIGGER_PIN_I(pin),
    .TB2_REQ_I(tb2), .TA0_REQ_I(ta0), .CONV_DATA_I(conv_data), .AFE_O(afe),
    .DMA_REQ_O(dma_req), .CONV_IRQ_O(irq));

  adcc_far_model #(.RES_W(10)) adcc_far_model_i (
    .clk_i(clk), .rst_i(rst), .fire_i(fire), .fire_code_i(fire_code),
    .conv_val_i(conv_val), .afe_i(afe), .pin_o(pin), .tb2_o(tb2), .ta0_o(ta0),
    .conv_data_o(conv_data));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // count transfer requests towards the dma side
  always @(posedge clk)
    if (dma_req === 1'b1)
      dma_cnt++;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp=%h got=%h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
      err_total++;
    rd      = prdata;
    se      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic trig(input logic [1:0] c);
    @(posedge clk);
    fire      <= 1'b1;
    fire_code <= c;
    @(posedge clk);
    fire      <= 1'b0;
  endtask

  // measure sample and convert phases of one pin
  task automatic run(input int samp, input int total);
    int n;
    int ns;
    int nc;
    n  = 0;
    ns = 0;
    nc = 0;
    @(negedge clk);
    while (afe.sample !== 1'b1 && n < 80)
    begin
      @(negedge clk);
      n++;
    end
    afe_cap = afe;
    while (afe.sample === 1'b1 && ns < 80)
    begin
      @(negedge clk);
      ns++;
    end
    while (afe.convert === 1'b1 && nc < 80)
    begin
      @(negedge clk);
      nc++;
    end
    chk("sample_len", ns, samp);
    chk("pin_len", ns + nc, total);
  endtask

  // configure while stopped, start, convert one pin and check where it landed
  task automatic conv(input logic [2:0] ch, input logic r10, input logic sh,
                      input logic [1:0] ext, input logic [2:0] f, input logic [1:0] t,
                      input logic dma, input logic rt);
    logic        trigger_source_bit;
    logic        seen;
    logic [7:0]  idx;
    logic [31:0] ex;
    int          d0;
    trigger_source_bit  = (t != 2'h3);
    seen = 1'b0;
    idx  = dma ? 8'h0 : (ext == 2'h1) ? 8'h0 : (ext == 2'h2) ? 8'h1 : {5'h0, ch};
    d0   = dma_cnt;
    apb(1'b1, adcc_pkg::OFS_CTRL_F, {29'h0, f});
    apb(1'b1, adcc_pkg::OFS_CTRL_B, {24'h0, ext, 2'b10, r10, 3'b000});
    apb(1'b1, adcc_pkg::OFS_CTRL_C, {25'h0, (trigger_source_bit ? t : 2'h0), 4'h0, sh});
    apb(1'b1, adcc_pkg::OFS_CTRL_D, {31'h0, dma});
    apb(1'b1, adcc_pkg::OFS_CTRL_A, {25'h0, 1'b0, trigger_source_bit, 2'b00, ch});
    if (trigger_source_bit)
    begin
      trig(t);
      repeat (12) @(negedge clk) seen |= (afe.sample === 1'b1);
    end
    // software start samples right after the write, so watch it meanwhile
    fork
      apb(1'b1, adcc_pkg::OFS_CTRL_A, {25'h0, 1'b1, trigger_source_bit, 2'b00, ch});
      if (!trigger_source_bit)
        run(sh ? 3 : 2, sh ? (r10 ? 33 : 28) : (r10 ? 59 : 47));
    join
    if (trigger_source_bit)
    begin
      repeat (6) @(negedge clk) seen |= (afe.sample === 1'b1);
      trig(t);
    end
    chk("no_early_start", seen, 1'b0);
    if (rt)
    begin
      run(sh ? 3 : 2, sh ? (r10 ? 33 : 28) : (r10 ? 59 : 47));
      apb(1'b1, adcc_pkg::OFS_CTRL_A, {25'h0, 1'b1, trigger_source_bit, 2'b00, ch});
      trig(t);
      repeat (14) @(negedge clk);
      trig(t);
    end
    if (trigger_source_bit)
      run(sh ? 3 : 2, sh ? (r10 ? 33 : 28) : (r10 ? 59 : 47));
    repeat (4) @(negedge clk);
    chk("dma_pulses", dma_cnt - d0, rt ? {31'h0, dma} << 1 : {31'h0, dma});
    chk("irq_set", irq, 1'b1);
    chk("ext_first", afe_cap.ext_first_in, ext == 2'h1);
    chk("ext_second", afe_cap.ext_second_in, ext[1]);
    chk("opamp", afe_cap.opamp_drive, ext == 2'h3);
    chk("chan", afe_cap.channel, ch);
    chk("ref", afe_cap.ref_on, 1'b1);
    chk("pull_en", afe_cap.pull_en, f[0]);
    if (f[0])
    begin
      chk("pull_dn", afe_cap.pull_down, f[2]);
      chk("self_test", afe_cap.self_test, f[1]);
    end
    // result read only after the pin completes, as wide as its resolution
    ex   = r10 ? {22'h0, 10'(conv_val)} : {24'h0, conv_val[9:2]};
    apb(1'b0, adcc_pkg::OFS_RES0 + (idx << 2), 32'h0);
    chk("result", rd, ex);
    apb(1'b0, adcc_pkg::OFS_CTRL_A, 32'h0);
    chk("start_done", rd[adcc_pkg::START_BIT], 1'b0);
    apb(1'b1, adcc_pkg::OFS_STATUS, 32'h2);
    chk("irq_clear", irq, 1'b0);
  endtask

  // watchdog: the whole run needs well under 20000 cycles
  initial
  begin
    #200_000;
    err_total++;
    final_report();
  end

  // main sequence
  initial
  begin
    err_total = 0;
    compares  = 0;
    dma_cnt   = 0;
    rst       = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h0;
    pwdata    = 32'h0;
    fire      = 1'b0;
    fire_code = 2'h0;
    conv_val  = 10'h0;
    void'($urandom(48458));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("irq_rst", irq, 1'b0);
    chk("dma_rst", dma_req, 1'b0);
    apb(1'b0, adcc_pkg::OFS_CTRL_A, 32'h0);
    chk("ctrl_a_rst", rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", se, 1'b1);
    apb(1'b1, adcc_pkg::OFS_RES0, 32'h3ff);
    apb(1'b0, adcc_pkg::OFS_RES0, 32'h0);
    chk("res_ro", rd, 32'h0);
    // reference first, start only after 1 us
    apb(1'b1, adcc_pkg::OFS_CTRL_B, 32'h20);
    repeat (100) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      conv_val <= 10'($urandom);
      // pin trigger never combined with dma
      conv(3'($urandom), 1'($urandom), 1'($urandom), 2'($urandom), 3'($urandom),
           2'(i), i >= 5, 1'b0);
    end
    // single sweep of two pins: mode set first, one interrupt at the end
    conv_val <= 10'($urandom);
    apb(1'b1, adcc_pkg::OFS_CTRL_B, 32'h0000_0028);
    apb(1'b1, adcc_pkg::OFS_CTRL_C, 32'h0000_0001);
    apb(1'b1, adcc_pkg::OFS_CTRL_D, 32'h0000_0000);
    apb(1'b1, adcc_pkg::OFS_CTRL_A, 32'h0000_0010);
    apb(1'b1, adcc_pkg::OFS_CTRL_A, 32'h0000_0050);
    repeat (36) @(negedge clk);
    apb(1'b0, adcc_pkg::OFS_CTRL_A, 32'h0000_0000);
    chk("sweep_busy", rd[adcc_pkg::START_BIT], 1'b1);
    chk("sweep_mid_irq", irq, 1'b0);
    repeat (40) @(negedge clk);
    chk("sweep_irq", irq, 1'b1);
    apb(1'b0, adcc_pkg::OFS_RES0, 32'h0000_0000);
    chk("sweep_res0", rd, {22'h0, conv_val});
    apb(1'b0, adcc_pkg::OFS_RES0 + 8'h04, 32'h0000_0000);
    chk("sweep_res1", rd, {22'h0, conv_val});
    apb(1'b1, adcc_pkg::OFS_STATUS, 32'h0000_0002);
    conv_val <= 10'h2c5;
    conv(3'h6, 1'b1, 1'b1, 2'h0, 3'h0, 2'h2, 1'b1, 1'b1);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
